/* File: design/ocp_pkg.sv */
/*
  Shared constants and types of the output clock prescaler.
  Assumes a 32-bit classic Wishbone register bus and one CPU clock.
*/
package ocp_pkg;
  localparam int unsigned DIV_W = 8;
  localparam int unsigned ADR_W = 8;

  // Byte addresses of the register words
  localparam logic [ADR_W-1:0] SYS_CFG_OFS = 8'h00;
  localparam logic [ADR_W-1:0] EXT_CFG_OFS = 8'h04;
  localparam logic [ADR_W-1:0] DIV_OFS     = 8'h08;
  localparam logic [ADR_W-1:0] STATUS_OFS  = 8'h0C;

  // Field positions
  localparam int unsigned CLK_OUT_EN_BIT  = 0;
  localparam int unsigned EXT_PER_EN_BIT  = 1;
  localparam int unsigned MISC_EXT_EN_BIT = 0;
  localparam int unsigned STAT_RUN_BIT    = 0;
  localparam int unsigned STAT_BYP_BIT    = 1;
  localparam int unsigned STAT_FAC_LSB    = 8;

  // Values after reset
  localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;
  localparam logic [DIV_W-1:0] FAC_ONE   = 8'h01;

  typedef struct packed {
    logic clock_output_enable;
    logic extension_peripherals_enable;
    logic misc_extension_enable;
  } ocp_ctrl_t;

  // Zero and one both mean undivided
  function automatic logic [DIV_W-1:0] eff_factor(input logic [DIV_W-1:0] f);
    eff_factor = (f <= FAC_ONE) ? FAC_ONE : f;
  endfunction
endpackage

/* File: design/ocp_divider.sv */
/*
  Counter that divides the CPU clock by a programmable factor.
  Assumes the factor input is a register on the same clock.
*/
module ocp_divider #(
  parameter int unsigned W = ocp_pkg::DIV_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] factor_i,
  output logic              clk_div_o,
  output logic              bypass_o,
  output logic [W-1:0]      active_factor_o
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] fac_reg;
  logic         out_reg;
  logic [W-1:0] new_fac;
  logic         wrap;
  logic [W-1:0] cnt_next;
  logic         out_next;

  assign new_fac  = ocp_pkg::eff_factor(factor_i);
  // A new factor is taken only at a period boundary or while stopped, so no runt pulse  // see R05
  assign wrap     = (cnt_reg == W'(fac_reg - 1'b1));
  assign cnt_next = wrap ? '0 : W'(cnt_reg + 1'b1);
  assign out_next = wrap ? (new_fac > ocp_pkg::FAC_ONE)
                         : (cnt_next < W'(fac_reg >> 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      fac_reg <= ocp_pkg::FAC_ONE; // see R05
      out_reg <= 1'b0;
    end else if (!run_i) begin
      cnt_reg <= '0;
      fac_reg <= new_fac;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      fac_reg <= wrap ? new_fac : fac_reg; // see R05
      out_reg <= out_next;
    end
  end

  assign clk_div_o       = out_reg;
  assign bypass_o        = (fac_reg == ocp_pkg::FAC_ONE);
  assign active_factor_o = fac_reg;
endmodule

/* File: design/ocp_top.sv */
/*
  Output clock prescaler: drives the CPU clock, whole or divided, onto
  the clock output pin, with its enables and divider reached over a
  classic Wishbone slave.
  Assumes CLOCK_I is the CPU clock and that the pin pad accepts a
  gated clock on CLK_OUT_O.
*/
// Function
// R01: Clock output enabled with no prescaling drives the undivided CPU clock.
// R02: Divider writable only with both extension enables set; pin then divides.
// R03: Clock output enable clear means no clock on the pin at all.
// R04: Divider lives in its own register on the extension bus.
// R05: Synchronous divider; zero or reset is divide-by-one; change at boundary.
module ocp_top #(
  parameter int unsigned DIV_W = ocp_pkg::DIV_W,
  parameter int unsigned ADR_W = ocp_pkg::ADR_W
) (
  input  wire logic             CLOCK_I,
  input  wire logic             RST_I,
  input  wire logic             CYC_I,
  input  wire logic             STB_I,
  input  wire logic             WE_I,
  input  wire logic [ADR_W-1:0] ADR_I,
  input  wire logic [3:0]       SEL_I,
  input  wire logic [31:0]      DAT_I,
  output logic      [31:0]      DAT_O,
  output logic                  ACK_O,
  output logic                  CLK_OUT_O,
  output logic                  CLK_OUT_OE_N_O
);
  ocp_pkg::ocp_ctrl_t ctrl_reg;
  logic [DIV_W-1:0]   divider_reg;
  logic               ack_reg;
  logic [31:0]        rdata_reg;
  logic               run_reg;

  logic [ADR_W-1:0]   word_adr;
  logic               req;
  logic               wr_now;
  logic               lane0;
  logic               hit_sys;
  logic               hit_ext;
  logic               hit_div;
  logic               hit_stat;
  logic               div_unlocked;
  logic [31:0]        rdata_next;
  logic               clk_div;
  logic               bypass;
  logic [DIV_W-1:0]   active_factor;

  // Bus decode
  assign word_adr = {ADR_I[ADR_W-1:2], 2'b00};
  assign req      = CYC_I & STB_I;
  // Writes take effect on the edge where the master sees ack
  assign wr_now   = req & WE_I & ack_reg;
  assign lane0    = SEL_I[0];
  assign hit_sys  = (word_adr == ocp_pkg::SYS_CFG_OFS);
  assign hit_ext  = (word_adr == ocp_pkg::EXT_CFG_OFS);
  assign hit_div  = (word_adr == ocp_pkg::DIV_OFS); // see R04
  assign hit_stat = (word_adr == ocp_pkg::STATUS_OFS);

  // The factor is locked unless both extension enables are on
  assign div_unlocked = ctrl_reg.misc_extension_enable
                      & ctrl_reg.extension_peripherals_enable; // see R02

  // Read data; unmapped words read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_sys) begin
      rdata_next[ocp_pkg::CLK_OUT_EN_BIT] = ctrl_reg.clock_output_enable;
      rdata_next[ocp_pkg::EXT_PER_EN_BIT] = ctrl_reg.extension_peripherals_enable;
    end else if (hit_ext) begin
      rdata_next[ocp_pkg::MISC_EXT_EN_BIT] = ctrl_reg.misc_extension_enable;
    end else if (hit_div) begin
      rdata_next[DIV_W-1:0] = divider_reg;
    end else if (hit_stat) begin
      rdata_next[ocp_pkg::STAT_RUN_BIT] = run_reg;
      rdata_next[ocp_pkg::STAT_BYP_BIT] = bypass;
      rdata_next[ocp_pkg::STAT_FAC_LSB +: DIV_W] = active_factor;
    end
  end

  // One wait state, ack drops the cycle after it was given
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= req & ~ack_reg;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_reg <= '0;
    end else if (wr_now & lane0) begin
      if (hit_sys) begin
        ctrl_reg.clock_output_enable          <= DAT_I[ocp_pkg::CLK_OUT_EN_BIT];
        ctrl_reg.extension_peripherals_enable <= DAT_I[ocp_pkg::EXT_PER_EN_BIT];
      end
      if (hit_ext) begin
        ctrl_reg.misc_extension_enable <= DAT_I[ocp_pkg::MISC_EXT_EN_BIT];
      end
    end
  end

  // Writes to a locked divider are acked but dropped
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      divider_reg <= ocp_pkg::DIV_RESET;
    end else if (wr_now & lane0 & hit_div & div_unlocked) begin // see R02
      divider_reg <= DAT_I[DIV_W-1:0];
    end
  end

  // Registered enable keeps the gate steady for a whole cycle
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= ctrl_reg.clock_output_enable;
    end
  end

  ocp_divider #(
    .W (DIV_W)
  ) u_div (
    .clk_i           (CLOCK_I),
    .rst_i           (RST_I),
    .run_i           (run_reg),
    .factor_i        (divider_reg),
    .clk_div_o       (clk_div),
    .bypass_o        (bypass),
    .active_factor_o (active_factor)
  );

  // Undivided mode gates the CPU clock itself; the enable changes just after
  // a rising edge, so the first and last high phase may be shortened
  assign CLK_OUT_O      = run_reg & (bypass ? CLOCK_I : clk_div); // see R01 see R03
  assign CLK_OUT_OE_N_O = ~run_reg; // see R03
  assign DAT_O          = rdata_reg;
  assign ACK_O          = ack_reg;
endmodule

/* File: tb/ocp_sva.sv */
/* Port checker for the output clock prescaler.
   Assumes it is bound to every ocp_top and sees its ports only. */
module ocp_sva (
  input wire logic        CLOCK_I,
  input wire logic        RST_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic        ACK_O,
  input wire logic        CLK_OUT_O,
  input wire logic        CLK_OUT_OE_N_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  wire cfg_wr = CYC_I & STB_I & WE_I & ACK_O & SEL_I[0] & (ADR_I == ocp_pkg::SYS_CFG_OFS);
  ack_latency_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack missing");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  pin_quiet_a: assert property (CLK_OUT_OE_N_O |-> !CLK_OUT_O)
    else $error("pin toggles while off");
  pin_on_a: assert property (cfg_wr && DAT_I[0] |-> ##[1:2] !CLK_OUT_OE_N_O)
    else $error("pin not driven");
  pin_off_a: assert property (cfg_wr && !DAT_I[0] |-> ##[1:2] CLK_OUT_OE_N_O)
    else $error("pin not released");
endmodule
bind ocp_top ocp_sva chk_u (.CLOCK_I, .RST_I, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I,
  .ACK_O, .CLK_OUT_O, .CLK_OUT_OE_N_O);

/* File: tb/ocp_clk_sink.sv */
/* Load on the output clock pin: measures the time between rising edges.
   Assumes the pin means nothing while its enable is high. */
module ocp_clk_sink (
  input  wire logic clk_i,
  input  wire logic oe_n_i,
  output realtime   per_o
);
  timeunit 1ns;
  timeprecision 100ps;
  realtime last = 0;
  initial per_o = 0;
  always @(posedge clk_i) if (!oe_n_i) begin
    per_o = $realtime - last;
    last = $realtime;
  end
endmodule

/* File: tb/tb_top.sv */
/* Self-checking bench for the output clock prescaler.
   Assumes ocp_top with its default widths and the checker bound to it. */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, clk_out, oe_n;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r, q;
  realtime     per;
  int          mismatches = 0, total_checks = 0;
  always #2 clk = ~clk;
  ocp_top dut_u (.CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .CLK_OUT_O(clk_out),
    .CLK_OUT_OE_N_O(oe_n));
  ocp_clk_sink sink_u (.clk_i(clk_out), .oe_n_i(oe_n), .per_o(per));
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Request stands until ack is seen at a rising edge; read data is taken at that edge.
  // No local limit: only the watchdog ends a hung wait.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, d, 4'hF};
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_r;
    {cyc, stb} <= 2'b00;
  endtask
  task t_reset;
    check("oe_n", oe_n, 32'h1);
    wb(0, ocp_pkg::STATUS_OFS, 32'h0);
    check("status", q, 32'h0000_0102);
  endtask
  task t_lock;
    wb(1, ocp_pkg::SYS_CFG_OFS, 32'h2);
    wb(1, ocp_pkg::DIV_OFS, 32'h4);
    wb(0, ocp_pkg::DIV_OFS, 32'h0);
    check("div locked", q, 32'h0);
    wb(0, 8'h10, 32'h0);
    check("unmapped", q, 32'h0);
  endtask
  task t_divide;
    logic [7:0] f;
    wb(1, ocp_pkg::SYS_CFG_OFS, 32'h3);
    // The enable lands one edge after the write; the first measured period is bogus
    repeat (6) @(posedge clk);
    check("period byp", 32'(int'(per)), 32'h4);
    wb(1, ocp_pkg::EXT_CFG_OFS, 32'h1);
    for (int i = 0; i < 3; i++) begin
      f = (i == 0) ? 8'h03 : (i == 1) ? 8'h00 : 8'h04;
      wb(1, ocp_pkg::DIV_OFS, {24'h0, f});
      repeat (30) @(posedge clk);
      if (f < 8'h02) f = 8'h01;
      check("period", 32'(int'(per)), 32'(4 * f));
      wb(0, ocp_pkg::STATUS_OFS, 32'h0);
      check("factor", {24'h0, q[15:8]}, {24'h0, f});
    end
  endtask
  task t_off;
    wb(1, ocp_pkg::SYS_CFG_OFS, 32'h2);
    wb(0, ocp_pkg::DIV_OFS, 32'h0);
    check("div kept", q, 32'h4);
    repeat (8) @(negedge clk) check("pin", {oe_n, clk_out}, 32'h2);
  endtask
  initial begin
    #20us;
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_lock;
    t_divide;
    t_off;
    report_and_stop;
  end
endmodule
